/* File: hdl/qse_status.sv */
// Status register bank with transition filters and a four-entry error queue.
// Assumes trip conditions and error pushes come from logic on SYS_CLK.
`timescale 1ns/1ps

// -----------------------------------------------------------------
// One status register: condition, filters, enable and event.
// -----------------------------------------------------------------
module qse_stat_reg
  import qse_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] EN_PRE = 16'hFFFF,
  parameter logic [15:0] PTR_PRE = 16'hFFFF,
  parameter logic [15:0] NTR_PRE = 16'hFFFF
) (
  // Clock and reset.
  input logic clk,
  input logic rst_n,
  // Live condition.
  input logic [15:0] cond,
  // Host access.
  input logic wr,
  input qse_view_t view,
  input logic [15:0] wdata,
  input logic preset,
  input logic evt_clr,
  // Register views.
  output logic [15:0] cond_o,
  output logic [15:0] evt_o,
  output logic [15:0] en_o,
  output logic [15:0] ptr_o,
  output logic [15:0] ntr_o
);
  logic [15:0] prev_q; // Condition one cycle ago.
  logic [15:0] evt_q; // Latched events.
  logic [15:0] en_q; // Enable mask.
  logic [15:0] ptr_q; // Rising edge filter.
  logic [15:0] ntr_q; // Falling edge filter.
  logic [15:0] set_w; // Events that pass the filters.

  // Unused positions never read as one.
  assign cond_o = cond & MASK;
  assign set_w = ((~prev_q & cond_o & ptr_q) | (prev_q & ~cond_o & ntr_q));
  assign evt_o = evt_q;
  assign en_o = en_q;
  assign ptr_o = ptr_q;
  assign ntr_o = ntr_q;

  // Edge memory for the filters.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 16'h0000;
    end else begin
      prev_q <= cond_o;
    end
  end

  // Events latch on a filtered edge; a new edge wins over a clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= 16'h0000;
    end else begin
      evt_q <= (evt_clr ? 16'h0000 : evt_q) | set_w;
    end
  end

  // Enable and filters: written by the host, loaded by preset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= EN_RST;
      ptr_q <= PTR_RST & MASK;
      ntr_q <= NTR_RST;
    end else if (preset) begin
      en_q <= EN_PRE & MASK;
      ptr_q <= PTR_PRE & MASK;
      ntr_q <= NTR_PRE & MASK;
    end else if (wr) begin
      if (view == V_EN) begin
        en_q <= wdata & MASK;
      end
      if (view == V_PTR) begin
        ptr_q <= wdata & MASK;
      end
      if (view == V_NTR) begin
        ntr_q <= wdata & MASK;
      end
    end
  end
endmodule

// -----------------------------------------------------------------
// Top: three registers, the error queue and the command port.
// -----------------------------------------------------------------
module qse_status
  import qse_pkg::*;
#(
  parameter int DEPTH = Q_DEPTH
) (
  // Clock and reset.
  input logic SYS_CLK,
  input logic ARST_N,
  // Command port.
  input logic CMD_VALID,
  input qse_cmd_t CMD,
  output logic CMD_READY,
  // Answer port.
  output logic RSP_VALID,
  output qse_rsp_t RSP,
  input logic RSP_READY,
  // Trip conditions.
  input logic TRIP_OVER,
  input logic TRIP_UNDER,
  input logic TRIP_HOT,
  // Error reports.
  input logic ERR_PUSH,
  input qse_err_t ERR_IN,
  // Status byte contributions.
  output logic STB_ERR_QUEUE,
  output logic STB_QUAL_SUMMARY
);
  // ---------------------------------------------------------------
  // Reset release and command decode.
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q; // Reset release chain.
  logic rst_n; // Released reset.
  qse_state_t state_q; // Command or query idle, or answer held.
  qse_rsp_t rsp_q; // Held answer.
  logic acc; // Command taken this cycle.
  logic cls; // Clear status taken.
  logic preset; // Preset taken.
  logic dev_rst; // Device reset taken.
  logic pop; // Queue read taken.
  logic [2:0] cnt_q; // Entries held.
  logic [2:0] cnt_pop; // Count after a pop.
  logic push_ok; // Valid push this cycle.
  qse_err_t q_q [DEPTH]; // Queue, index 0 oldest.
  logic [15:0] c_q, c_l, c_t; // Condition views.
  logic [15:0] e_q, e_l, e_t; // Event views.
  logic [15:0] n_q, n_l, n_t; // Enable views.
  logic [15:0] p_q, p_l, p_t; // Rising filter views.
  logic [15:0] f_q, f_l, f_t; // Falling filter views.
  logic [15:0] qual_cond; // Quality condition from summaries.
  logic [15:0] lvl_cond; // Level condition.
  logic [15:0] thm_cond; // Thermal condition.
  logic [15:0] rd_data; // Register read mux.

  // Two-stage reset release.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // A device reset is taken even while an answer is held.
  assign CMD_READY = (state_q == ST_IDLE) || (CMD.op == OP_RST);
  assign acc = CMD_VALID && CMD_READY;
  assign cls = acc && (CMD.op == OP_CLS);
  assign preset = acc && (CMD.op == OP_PRESET);
  assign dev_rst = acc && (CMD.op == OP_RST);
  assign pop = acc && ((CMD.op == OP_ERR_FULL) || (CMD.op == OP_ERR_CODE));

  // ---------------------------------------------------------------
  // Status registers.
  // ---------------------------------------------------------------
  // Trip inputs land on their documented positions.
  always_comb begin
    lvl_cond = 16'h0000;
    thm_cond = 16'h0000;
    lvl_cond[OVER_BIT] = TRIP_OVER;
    lvl_cond[UNDER_BIT] = TRIP_UNDER;
    thm_cond[HOT_BIT] = TRIP_HOT;
  end

  // Summaries OR the enabled events of each sub-register.
  always_comb begin
    qual_cond = 16'h0000;
    qual_cond[LVL_BIT] = |(e_l & n_l);
    qual_cond[THM_BIT] = |(e_t & n_t);
  end

  // Sixteen-bit quality register.
  qse_stat_reg #(.MASK(QUAL_MASK), .EN_PRE(QUAL_EN_PRE), .PTR_PRE(QUAL_PTR_PRE),
    .NTR_PRE(QUAL_NTR_PRE)) u_qual (
    .clk(SYS_CLK), .rst_n(rst_n), .cond(qual_cond),
    .wr(acc && CMD.op == OP_WRITE && CMD.sel == SEL_QUAL), .view(CMD.view),
    .wdata(CMD.wdata), .preset(preset),
    .evt_clr(cls || (acc && CMD.op == OP_READ && CMD.sel == SEL_QUAL && CMD.view == V_EVT)),
    .cond_o(c_q), .evt_o(e_q), .en_o(n_q), .ptr_o(p_q), .ntr_o(f_q));
  qse_stat_reg #(.MASK(LVL_MASK), .EN_PRE(SUB_PRE), .PTR_PRE(SUB_PRE),
    .NTR_PRE(SUB_PRE)) u_lvl (
    .clk(SYS_CLK), .rst_n(rst_n), .cond(lvl_cond),
    .wr(acc && CMD.op == OP_WRITE && CMD.sel == SEL_LVL), .view(CMD.view),
    .wdata(CMD.wdata), .preset(preset),
    .evt_clr(cls || (acc && CMD.op == OP_READ && CMD.sel == SEL_LVL && CMD.view == V_EVT)),
    .cond_o(c_l), .evt_o(e_l), .en_o(n_l), .ptr_o(p_l), .ntr_o(f_l));
  qse_stat_reg #(.MASK(THM_MASK), .EN_PRE(SUB_PRE), .PTR_PRE(SUB_PRE),
    .NTR_PRE(SUB_PRE)) u_thm (
    .clk(SYS_CLK), .rst_n(rst_n), .cond(thm_cond),
    .wr(acc && CMD.op == OP_WRITE && CMD.sel == SEL_THM), .view(CMD.view),
    .wdata(CMD.wdata), .preset(preset),
    .evt_clr(cls || (acc && CMD.op == OP_READ && CMD.sel == SEL_THM && CMD.view == V_EVT)),
    .cond_o(c_t), .evt_o(e_t), .en_o(n_t), .ptr_o(p_t), .ntr_o(f_t));

  // Register read mux over the selected view.
  always_comb begin
    rd_data = 16'h0000;
    case (CMD.view)
      V_COND: rd_data = (CMD.sel == SEL_QUAL) ? c_q : (CMD.sel == SEL_LVL) ? c_l : c_t;
      V_EVT: rd_data = (CMD.sel == SEL_QUAL) ? e_q : (CMD.sel == SEL_LVL) ? e_l : e_t;
      V_EN: rd_data = (CMD.sel == SEL_QUAL) ? n_q : (CMD.sel == SEL_LVL) ? n_l : n_t;
      V_PTR: rd_data = (CMD.sel == SEL_QUAL) ? p_q : (CMD.sel == SEL_LVL) ? p_l : p_t;
      V_NTR: rd_data = (CMD.sel == SEL_QUAL) ? f_q : (CMD.sel == SEL_LVL) ? f_l : f_t;
      default: rd_data = 16'h0000;
    endcase
  end

  // Enabled quality events feed the status byte.
  assign STB_QUAL_SUMMARY = |(e_q & n_q);

  // ---------------------------------------------------------------
  // Error queue.
  // ---------------------------------------------------------------
  // Code zero means no error and is never queued.
  assign push_ok = ERR_PUSH && (ERR_IN.code != NO_ERR);
  assign cnt_pop = cnt_q - {2'b00, (pop && cnt_q != 3'h0)};

  // Shift queue; a pop frees the head before a push lands.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      for (int i = 0; i < DEPTH; i++) begin
        q_q[i] <= '0;
      end
    end else if (cls) begin
      cnt_q <= 3'h0;
    end else begin
      if (pop && cnt_q != 3'h0) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          q_q[i] <= q_q[i + 1];
        end
      end
      if (push_ok && cnt_pop < 3'(DEPTH)) begin
        q_q[cnt_pop[1:0]] <= ERR_IN;
        cnt_q <= cnt_pop + 3'h1;
      end else if (push_ok) begin
        q_q[DEPTH - 1].code <= OVF_CODE;
        q_q[DEPTH - 1].len <= 8'h00;
        cnt_q <= cnt_pop;
      end else begin
        cnt_q <= cnt_pop;
      end
    end
  end

  // Status byte bit while anything is queued.
  assign STB_ERR_QUEUE = (cnt_q != 3'h0);

  // ---------------------------------------------------------------
  // Answer and idle states.
  // ---------------------------------------------------------------
  // Queries load an answer; device reset drops it.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      rsp_q <= '0;
    end else if (dev_rst) begin
      state_q <= ST_IDLE;
      rsp_q <= '0;
    end else if (acc) begin
      case (CMD.op)
        OP_READ: begin
          state_q <= ST_ANSWER;
          rsp_q <= '{data: rd_data, text: 1'b0, len: 8'h00};
        end
        OP_ERR_FULL: begin
          state_q <= ST_ANSWER;
          rsp_q <= '{data: (cnt_q != 3'h0) ? q_q[0].code : NO_ERR, text: 1'b1,
                     len: (cnt_q != 3'h0) ? q_q[0].len : 8'h00};
        end
        OP_ERR_CODE: begin
          state_q <= ST_ANSWER;
          rsp_q <= '{data: (cnt_q != 3'h0) ? q_q[0].code : NO_ERR, text: 1'b0, len: 8'h00};
        end
        OP_ERR_COUNT: begin
          state_q <= ST_ANSWER;
          rsp_q <= '{data: {13'h0000, cnt_q}, text: 1'b0, len: 8'h00};
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end else if (state_q == ST_ANSWER && RSP_READY) begin
      state_q <= ST_IDLE;
    end
  end

  assign RSP_VALID = (state_q == ST_ANSWER);
  assign RSP = rsp_q;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_pop_full;
    acc && CMD.op == OP_ERR_FULL && cnt_q != 3'h0;
  endsequence

  queue_order_a: assert property (s_pop_full |=> RSP.data == $past(q_q[0].code))
    else $error("oldest entry not answered");
  queue_ovf_a: assert property ((push_ok && !pop && !cls && cnt_q == 3'(DEPTH))
    |=> q_q[DEPTH - 1].code == OVF_CODE && cnt_q == 3'(DEPTH))
    else $error("overflow not marked");
  queue_cap_a: assert property (cnt_q <= 3'(DEPTH))
    else $error("queue above depth");
  // A kept push must raise the queue bit at the next edge, pop or not.
  err_bit_a: assert property ((push_ok && !cls) |=> STB_ERR_QUEUE)
    else $error("queue bit wrong");
  count_ans_a: assert property ((acc && CMD.op == OP_ERR_COUNT)
    |=> RSP_VALID && RSP.data == {13'h0000, $past(cnt_q)})
    else $error("count answer wrong");
  rst_idle_a: assert property (dev_rst |=> !RSP_VALID && CMD_READY)
    else $error("device reset left answer");
  // Clear status empties the queue; only an edge in the same cycle may leave an event.
  cls_empty_a: assert property (cls |=> cnt_q == 3'h0
    && e_q == $past(u_qual.set_w))
    else $error("clear status left state");
  preset_val_a: assert property (preset |=> n_q == QUAL_EN_PRE && n_l == LVL_MASK
    && f_q == QUAL_NTR_PRE)
    else $error("preset values wrong");
  sum_bit_a: assert property (c_q[LVL_BIT] == |(e_l & n_l)
    && c_q[THM_BIT] == |(e_t & n_t))
    else $error("summary bit wrong");
  zero_bits_a: assert property ((c_q & ~QUAL_MASK) == 16'h0000
    && (n_q & ~QUAL_MASK) == 16'h0000)
    else $error("unused bit set");
endmodule

/* File: inc/qse_pkg.sv */
// Shared constants, enumerations and carriers of the status and error queue block.
// Assumes one clock domain and a host that issues one command at a time.
//
// Contract
// - Sixteen-bit quality warning status register.
// - Bit 0 summarises level trip register.
// - Bit 4 summarises thermal trip register.
// - Summary is OR of sub-register bits.
// - Level bit 0 over, bit 1 under.
// - Thermal bit 0 near overheating.
// - Condition, event, enable, filters readable; masks writable.
// - Entry code is signed sixteen bits.
// - Code zero means no error; fixed text.
// - Text plus info at most 255 characters.
// - Errors delivered first in, first out.
// - Overflow keeps oldest, newest becomes -350.
// - Queue holds at most four entries.
// - Non-empty queue sets status byte bit.
// - Full query returns oldest with text, removes.
// - Code query returns oldest code, removes.
// - Count query returns stored entry count.
// - Device reset leaves status and queue alone.
// - Device reset forces command and query idle.
// - Clear status empties events and queue.
// - Preset loads enables and filters only.
package qse_pkg;
  // ---------------------------------------------------------------
  // Widths, positions and codes.
  // ---------------------------------------------------------------
  localparam int QS_W = 16;
  localparam int Q_DEPTH = 4;
  localparam int LVL_BIT = 0;
  localparam int THM_BIT = 4;
  localparam int OVER_BIT = 0;
  localparam int UNDER_BIT = 1;
  localparam int HOT_BIT = 0;
  localparam logic [15:0] QUAL_MASK = 16'h0011;
  localparam logic [15:0] LVL_MASK = 16'h0003;
  localparam logic [15:0] THM_MASK = 16'h0001;
  localparam logic [15:0] OVF_CODE = 16'hFEA2;
  localparam logic [15:0] NO_ERR = 16'h0000;
  // ---------------------------------------------------------------
  // Reset and preset values.
  // ---------------------------------------------------------------
  localparam logic [15:0] EN_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'hFFFF;
  localparam logic [15:0] NTR_RST = 16'h0000;
  localparam logic [15:0] QUAL_EN_PRE = 16'h0000;
  localparam logic [15:0] QUAL_PTR_PRE = 16'hFFFF;
  localparam logic [15:0] QUAL_NTR_PRE = 16'h0000;
  localparam logic [15:0] SUB_PRE = 16'hFFFF;
  // ---------------------------------------------------------------
  // Commands, selectors and carriers.
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_READ = 4'h1, OP_WRITE = 4'h2, OP_ERR_FULL = 4'h3,
    OP_ERR_CODE = 4'h4, OP_ERR_COUNT = 4'h5, OP_CLS = 4'h6,
    OP_PRESET = 4'h7, OP_RST = 4'h8
  } qse_op_t;
  typedef enum logic [1:0] {
    SEL_QUAL = 2'h0, SEL_LVL = 2'h1, SEL_THM = 2'h2
  } qse_sel_t;
  typedef enum logic [2:0] {
    V_COND = 3'h0, V_EVT = 3'h1, V_EN = 3'h2, V_PTR = 3'h3, V_NTR = 3'h4
  } qse_view_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0, ST_ANSWER = 1'b1
  } qse_state_t;
  typedef struct packed {
    qse_op_t op;
    qse_sel_t sel;
    qse_view_t view;
    logic [15:0] wdata;
  } qse_cmd_t;
  typedef struct packed {
    logic [15:0] code;
    logic [7:0] len;
  } qse_err_t;
  typedef struct packed {
    logic [15:0] data;
    logic text;
    logic [7:0] len;
  } qse_rsp_t;
endpackage

/* File: dv/qse_host.sv */
// Remote host model that issues commands and collects answers.
// Assumes the bench calls xfer and that every input moves on the falling edge.
`timescale 1ns/1ps

module qse_host
  import qse_pkg::*;
(
  // Clock.
  input logic clk,
  // Command port.
  output qse_cmd_t cmd,
  output logic cmd_valid,
  input logic cmd_ready,
  // Answer port.
  input logic rsp_valid,
  input qse_rsp_t rsp,
  output logic rsp_ready
);
  int n_late; // Commands that were never taken within the wait limit.

  // Idle levels at time zero.
  initial begin
    n_late = 0;
    cmd = '0;
    cmd_valid = 1'b0;
    rsp_ready = 1'b0;
  end

  // One command; a query waits stall cycles before taking its answer, or keeps it if hold.
  task automatic xfer(input qse_op_t op, input int s, input int v, input logic [15:0] wd,
                      input int stall, input bit hold, output qse_rsp_t r);
    int n;
    n = 0;
    @(negedge clk);
    cmd = '{op: op, sel: qse_sel_t'(s), view: qse_view_t'(v), wdata: wd};
    cmd_valid = 1'b1;
    #1;
    // The command is held until an edge sees the port ready.
    while (!cmd_ready && n < 50) begin
      @(negedge clk);
      #1;
      n++;
    end
    // A command that is never taken is counted as a failure by the bench.
    if (!cmd_ready) begin
      n_late++;
    end
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    // A released bus does not keep showing the last word.
    cmd.wdata = ~cmd.wdata;
    r = '0;
    if (op inside {OP_READ, OP_ERR_FULL, OP_ERR_CODE, OP_ERR_COUNT}) begin
      // An answer that is not flagged valid reads as unknown and fails any compare.
      r = rsp_valid ? rsp : 'x;
      if (!hold) begin
        repeat (stall) @(negedge clk);
        rsp_ready = 1'b1;
        @(negedge clk);
        rsp_ready = 1'b0;
      end
    end
  endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench of the status bank and error queue, against a queue model.
// Assumes the host model in qse_host and the package constants of qse_pkg.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb;
  import qse_pkg::*;
  // Design-side signals.
  logic SYS_CLK, ARST_N, CMD_VALID, CMD_READY, RSP_VALID, RSP_READY;
  logic TRIP_OVER, TRIP_UNDER, TRIP_HOT, ERR_PUSH, STB_ERR_QUEUE, STB_QUAL_SUMMARY;
  qse_cmd_t CMD;
  qse_rsp_t RSP, r;
  qse_err_t ERR_IN;
  // Model state and counters.
  logic [15:0] m_en [3];
  logic [15:0] m_ptr [3];
  logic [15:0] m_ntr [3];
  qse_err_t m_q [$];
  logic [31:0] lf;
  int n_fail, tests_run;

  qse_status dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP(RSP), .RSP_READY(RSP_READY),
    .TRIP_OVER(TRIP_OVER), .TRIP_UNDER(TRIP_UNDER), .TRIP_HOT(TRIP_HOT),
    .ERR_PUSH(ERR_PUSH), .ERR_IN(ERR_IN), .STB_ERR_QUEUE(STB_ERR_QUEUE),
    .STB_QUAL_SUMMARY(STB_QUAL_SUMMARY));
  qse_host host (.clk(SYS_CLK), .cmd(CMD), .cmd_valid(CMD_VALID), .cmd_ready(CMD_READY),
    .rsp_valid(RSP_VALID), .rsp(RSP), .rsp_ready(RSP_READY));

  // Free-running 200 MHz clock.
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  // ---------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [15:0] msk(int s);
    return (s == 0) ? QUAL_MASK : (s == 1) ? LVL_MASK : THM_MASK;
  endfunction
  // Read one view with a random answer stall and compare.
  task automatic rd(int s, int v, logic [15:0] e);
    lf = nx(lf);
    host.xfer(OP_READ, s, v, lf[15:0], lf[1:0] % 3, 1'b0, r);
    `CHK(r.data, e)
  endtask
  // Write one view; only mask bits of enables and filters stick.
  task automatic wr(int s, int v, logic [15:0] d);
    host.xfer(OP_WRITE, s, v, d, 0, 1'b0, r);
    if (v == 2) m_en[s] = d & msk(s);
    if (v == 3) m_ptr[s] = d & msk(s);
    if (v == 4) m_ntr[s] = d & msk(s);
  endtask
  task automatic all_regs();
    for (int s = 0; s < 3; s++) begin
      rd(s, 2, m_en[s]);
      rd(s, 3, m_ptr[s]);
      rd(s, 4, m_ntr[s]);
    end
  endtask
  // One error report; a full queue turns its newest slot into the overflow code.
  task automatic push(logic [15:0] c);
    @(negedge SYS_CLK);
    lf = nx(lf);
    ERR_IN = '{code: c, len: lf[7:0]};
    ERR_PUSH = 1'b1;
    @(negedge SYS_CLK);
    ERR_PUSH = 1'b0;
    ERR_IN = ~ERR_IN;
    // Code zero is never queued.
    if (c != NO_ERR && m_q.size() < Q_DEPTH) m_q.push_back(qse_err_t'{code: c, len: lf[7:0]});
    else if (c != NO_ERR) m_q[Q_DEPTH-1] = qse_err_t'{code: OVF_CODE, len: 8'h00};
  endtask
  // Pop query: oldest entry or zero when empty; only the full query carries text.
  task automatic pop(qse_op_t op);
    qse_err_t e;
    e = (m_q.size() > 0) ? m_q.pop_front() : qse_err_t'('0);
    host.xfer(op, 0, 0, 16'h0000, 1, 1'b0, r);
    `CHK(r.data, e.code)
    `CHK(r.text, op == OP_ERR_FULL)
    `CHK(r.len, (op == OP_ERR_FULL) ? e.len : 8'h00)
  endtask
  task automatic count();
    host.xfer(OP_ERR_COUNT, 0, 0, 16'h0000, 2, 1'b0, r);
    `CHK(r.data, 16'(m_q.size()))
  endtask
  task automatic end_of_test();
    // Commands the host gave up on count as mismatches.
    n_fail += host.n_late;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the sequence needs.
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    tests_run = 0;
    lf = 32'h8834;
    ARST_N = 1'b0;
    {TRIP_OVER, TRIP_UNDER, TRIP_HOT, ERR_PUSH} = 4'h0;
    ERR_IN = '0;
    for (int s = 0; s < 3; s++) begin
      m_en[s] = EN_RST;
      m_ptr[s] = PTR_RST & msk(s);
      m_ntr[s] = NTR_RST;
    end
    repeat (16) @(negedge SYS_CLK);
    ARST_N = 1'b1;
    repeat (3) @(negedge SYS_CLK);
    all_regs();
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      wr(lf[3:0] % 3, 2 + lf[7:4] % 3, lf[31:16]);
    end
    all_regs();
    // Preset touches enables and filters only.
    push(16'h0123);
    host.xfer(OP_PRESET, 0, 0, 16'h0000, 0, 1'b0, r);
    for (int s = 0; s < 3; s++) begin
      m_en[s] = (s == 0) ? QUAL_EN_PRE : SUB_PRE & msk(s);
      m_ptr[s] = ((s == 0) ? QUAL_PTR_PRE : SUB_PRE) & msk(s);
      m_ntr[s] = (s == 0) ? QUAL_NTR_PRE : SUB_PRE & msk(s);
    end
    all_regs();
    count();
    // Trip conditions, summaries and filtered events.
    TRIP_OVER = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    rd(1, 0, 16'h0001);
    rd(0, 0, 16'h0001);
    TRIP_HOT = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    rd(2, 0, 16'h0001);
    rd(0, 0, 16'h0011);
    wr(0, 2, 16'hFFFF);
    repeat (4) @(negedge SYS_CLK);
    `CHK(STB_QUAL_SUMMARY, 1'b1)
    rd(1, 1, 16'h0001);
    rd(1, 1, 16'h0000);
    repeat (4) @(negedge SYS_CLK);
    rd(0, 0, 16'h0010);
    rd(0, 1, 16'h0011);
    `CHK(STB_QUAL_SUMMARY, 1'b0)
    wr(1, 3, 16'h0000);
    TRIP_UNDER = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    rd(1, 0, 16'h0003);
    rd(1, 1, 16'h0000);
    TRIP_UNDER = 1'b0;
    repeat (6) @(negedge SYS_CLK);
    rd(1, 1, 16'h0002);
    // Queue fill past its depth, then drain in order and past empty.
    push(NO_ERR);
    for (int i = 0; i < 5; i++) begin
      lf = nx(lf);
      push(lf[15:0] | 16'h0001);
    end
    count();
    `CHK(STB_ERR_QUEUE, 1'b1)
    for (int i = 0; i < 4; i++) pop(i[0] ? OP_ERR_CODE : OP_ERR_FULL);
    pop(OP_ERR_CODE);
    `CHK(STB_ERR_QUEUE, 1'b0)
    // Clear status empties the queue and events.
    push(16'h0042);
    push(16'h8001);
    host.xfer(OP_CLS, 0, 0, 16'h0000, 0, 1'b0, r);
    m_q.delete();
    count();
    rd(2, 1, 16'h0000);
    // Device reset drops a held answer and leaves the rest alone.
    push(16'h0077);
    host.xfer(OP_ERR_COUNT, 0, 0, 16'h0000, 0, 1'b1, r);
    `CHK(r.data, 16'(m_q.size()))
    `CHK(RSP_VALID, 1'b1)
    host.xfer(OP_RST, 0, 0, 16'h0000, 0, 1'b0, r);
    `CHK(RSP_VALID, 1'b0)
    `CHK(CMD_READY, 1'b1)
    all_regs();
    count();
    end_of_test();
  end
endmodule
